// file: hw/i2c_tx_pkg.sv
/*
  Shared constants and types for the two-wire slave transmit block:
  register offsets, field positions, reset values and bus carrier types.
  Assumes a 32-bit AHB-Lite register bus and an 8-bit serial byte.
*/
package i2c_tx_pkg;
  // Register byte offsets
  localparam logic [7:0] ctrl_off = 8'h00;        // Control
  localparam logic [7:0] status_off = 8'h04;      // Serial port status
  localparam logic [7:0] data_off = 8'h08;        // Data buffer
  localparam logic [7:0] irq_stat_off = 8'h0c;    // Sticky events, write one to clear
  localparam logic [7:0] irq_mask_off = 8'h10;    // Event mask
  localparam int addr_lsb_w = 8;                  // Decoded address width

  // Control fields
  localparam int ctrl_en_bit = 0;                 // Block enable
  localparam int ctrl_ckp_bit = 1;                // Clock release
  localparam int ctrl_start_ie_bit = 2;           // Interrupt on start
  localparam int ctrl_slave_collision_detect_en_bit = 3;              // Slave collision detect enable
  localparam int ctrl_addr_lsb = 8;               // Own 7-bit address
  localparam int ctrl_addr_msb = 14;
  localparam logic [6:0] own_addr_rst = 7'h00;    // Own address after reset

  // Status fields
  localparam int st_bf_bit = 0;                   // Buffer full
  localparam int st_rw_bit = 1;                   // Read indication
  localparam int st_start_bit = 2;                // Start seen
  localparam int st_stop_bit = 3;                 // Stop seen
  localparam int st_ack_status_bit_bit = 4;              // Acknowledge status from master
  localparam int st_addressed_bit = 5;            // Currently addressed

  // Interrupt status fields
  localparam int irq_port_bit = 0;                // Serial port event flag
  localparam int irq_bcl_bit = 1;                 // Bus collision flag
  localparam int irq_w = 2;

  // Byte framing
  localparam logic [3:0] bits_per_byte = 4'h8;    // Data bits per byte

  // AHB transfer type bit marking an active transfer
  localparam int htrans_active_bit = 1;

  // Latched address phase
  typedef struct packed {
    logic valid;
    logic write;
    logic [7:0] addr;
  } ahb_req_t;

  // Synchronised bus levels and their edges
  typedef struct packed {
    logic scl;
    logic sda;
    logic scl_rise;
    logic scl_fall;
    logic start;
    logic stop;
  } bus_evt_t;
endpackage : i2c_tx_pkg

// file: hw/i2c_slave_transmit.sv
/*
  Slave transmit path of a two-wire serial port with an AHB-Lite register
  slave. Answers a read address, stretches the clock while software loads
  each byte, shifts bytes out, samples the master's acknowledge and flags
  collisions. Assumes open-drain pads outside (output enable high pulls the
  line low) and a bus clock far slower than hclk.
*/
// The AHB-Lite interface to the registers and the address map were decided locally.
`timescale 1ns/10ps
`default_nettype none
module i2c_slave_transmit (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic [31:0] hrdata,
  output logic hreadyout,
  output logic hresp,
  input wire logic scl_i,
  output logic scl_o,
  output logic scl_oe,
  input wire logic sda_i,
  output logic sda_o,
  output logic sda_oe,
  output logic irq
);
  // One-hot protocol states
  typedef enum logic [5:0] {
    st_idle = 6'b000001,    // Not addressed
    st_addr = 6'b000010,    // Receiving address byte
    st_aack = 6'b000100,    // Driving address acknowledge
    st_hold = 6'b001000,    // Clock stretched, waiting for software
    st_tx = 6'b010000,      // Shifting data out
    st_mack = 6'b100000     // Master acknowledge clock
  } state_t;

  state_t state_q;
  i2c_tx_pkg::ahb_req_t req_q;          // Address phase awaiting data phase
  i2c_tx_pkg::bus_evt_t ev;             // Decoded bus events
  logic [1:0] scl_sync_q;               // Two-stage synchroniser for SCL
  logic [1:0] sda_sync_q;               // Two-stage synchroniser for SDA
  logic scl_prev_q;                     // Synchronised SCL one cycle back
  logic sda_prev_q;                     // Synchronised SDA one cycle back
  logic [7:0] ctrl_q;                   // Enable, release and enables
  logic [6:0] own_addr_q;               // Own slave address
  logic [7:0] buf_q;                    // Data buffer
  logic [7:0] shift_q;                  // Shift register
  logic [3:0] cnt_q;                    // Bit counter in current byte
  logic bf_q;                           // Buffer full
  logic rw_q;                           // Read indication
  logic start_q;                        // Start seen
  logic stop_q;                         // Stop seen
  logic ack_status_bit_q;                      // Master acknowledge status
  logic [i2c_tx_pkg::irq_w-1:0] irq_stat_q;  // Sticky events
  logic [i2c_tx_pkg::irq_w-1:0] irq_mask_q;  // Event mask
  logic [i2c_tx_pkg::irq_w-1:0] irq_set;     // Events this cycle
  logic [31:0] rdata_d;                 // Read mux
  logic addr_take;                      // Address phase accepted
  logic wr_ctrl;                        // Data phase write strobes
  logic wr_data;
  logic wr_irq;
  logic wr_mask;
  logic rd_data;                        // Read of data buffer
  logic addr_hit;                       // Received address matches
  logic collide;                        // Released SDA seen low
  logic port_evt;                       // Serial port event
  logic bcl_evt;                        // Collision event

  // Synchronisers; first stage feeds only the second
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      scl_sync_q <= 2'h3;
      sda_sync_q <= 2'h3;
      scl_prev_q <= 1'b1;
      sda_prev_q <= 1'b1;
    end else begin
      scl_sync_q <= {scl_sync_q[0], scl_i};
      sda_sync_q <= {sda_sync_q[0], sda_i};
      scl_prev_q <= scl_sync_q[1];
      sda_prev_q <= sda_sync_q[1];
    end
  end

  // Edge and condition decode on synchronised levels
  always_comb begin
    ev.scl = scl_sync_q[1];
    ev.sda = sda_sync_q[1];
    ev.scl_rise = ev.scl & ~scl_prev_q;
    ev.scl_fall = ~ev.scl & scl_prev_q;
    // SDA moving while SCL stays high marks start or stop
    ev.start = ev.scl & scl_prev_q & ~ev.sda & sda_prev_q;
    ev.stop = ev.scl & scl_prev_q & ev.sda & ~sda_prev_q;
  end

  // Bus side decode
  assign addr_take = hsel & hready & htrans[i2c_tx_pkg::htrans_active_bit];
  assign wr_ctrl = req_q.valid & req_q.write & (req_q.addr == i2c_tx_pkg::ctrl_off);
  assign wr_data = req_q.valid & req_q.write & (req_q.addr == i2c_tx_pkg::data_off);
  assign wr_irq = req_q.valid & req_q.write & (req_q.addr == i2c_tx_pkg::irq_stat_off);
  assign wr_mask = req_q.valid & req_q.write & (req_q.addr == i2c_tx_pkg::irq_mask_off);
  assign rd_data = addr_take & ~hwrite
                   & (haddr[i2c_tx_pkg::addr_lsb_w-1:0] == i2c_tx_pkg::data_off);

  assign addr_hit = (shift_q[7:1] == own_addr_q) & shift_q[0];
  // Only a released one can be overridden; a driven zero cannot collide
  assign collide = (state_q == st_tx) & ev.scl_rise & shift_q[7] & ~ev.sda;
  assign bcl_evt = collide & ctrl_q[i2c_tx_pkg::ctrl_slave_collision_detect_en_bit];
  assign port_evt = ((state_q == st_aack) & ev.scl_fall)
                    | ((state_q == st_mack) & ev.scl_fall)
                    | (ev.start & ctrl_q[i2c_tx_pkg::ctrl_start_ie_bit]);
  assign irq_set = {bcl_evt, port_evt};

  // Address phase capture; data phase follows next cycle
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      req_q <= '0;
    end else begin
      req_q.valid <= addr_take;
      req_q.write <= hwrite;
      req_q.addr <= haddr[i2c_tx_pkg::addr_lsb_w-1:0];
    end
  end

  // Read mux; unmapped offsets read zero
  always_comb begin
    rdata_d = 32'h0000_0000;
    case (haddr[i2c_tx_pkg::addr_lsb_w-1:0])
      i2c_tx_pkg::ctrl_off: begin
        rdata_d[7:0] = ctrl_q;
        rdata_d[i2c_tx_pkg::ctrl_addr_msb:i2c_tx_pkg::ctrl_addr_lsb] = own_addr_q;
      end
      i2c_tx_pkg::status_off: begin
        rdata_d[i2c_tx_pkg::st_bf_bit] = bf_q;
        rdata_d[i2c_tx_pkg::st_rw_bit] = rw_q;
        rdata_d[i2c_tx_pkg::st_start_bit] = start_q;
        rdata_d[i2c_tx_pkg::st_stop_bit] = stop_q;
        rdata_d[i2c_tx_pkg::st_ack_status_bit_bit] = ack_status_bit_q;
        rdata_d[i2c_tx_pkg::st_addressed_bit] = (state_q != st_idle);
      end
      i2c_tx_pkg::data_off: rdata_d[7:0] = buf_q;
      i2c_tx_pkg::irq_stat_off: rdata_d[i2c_tx_pkg::irq_w-1:0] = irq_stat_q;
      i2c_tx_pkg::irq_mask_off: rdata_d[i2c_tx_pkg::irq_w-1:0] = irq_mask_q;
      default: rdata_d = 32'h0000_0000;
    endcase
  end

  // Bus answers: zero wait states, always OKAY
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hrdata <= 32'h0000_0000;
      hreadyout <= 1'b1;
      hresp <= 1'b0;
    end else begin
      hreadyout <= 1'b1;
      hresp <= 1'b0;
      if (addr_take && !hwrite) begin
        hrdata <= rdata_d;
      end
    end
  end

  // Control register; hardware clears the release bit when it stretches
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      ctrl_q <= 8'h00;
      own_addr_q <= i2c_tx_pkg::own_addr_rst;
    end else begin
      if (wr_ctrl) begin
        ctrl_q <= hwdata[7:0];
        own_addr_q <= hwdata[i2c_tx_pkg::ctrl_addr_msb:i2c_tx_pkg::ctrl_addr_lsb];
      end
      // Hardware clear wins: a stretch must never be lost
      if ((state_q == st_aack || state_q == st_mack) && ev.scl_fall) begin
        ctrl_q[i2c_tx_pkg::ctrl_ckp_bit] <= 1'b0;
      end
    end
  end

  // Sticky interrupt status and mask; set wins over clear
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      irq_stat_q <= '0;
      irq_mask_q <= '0;
      irq <= 1'b0;
    end else begin
      irq_stat_q <= (irq_stat_q & ~(wr_irq ? hwdata[i2c_tx_pkg::irq_w-1:0] : '0))
                    | irq_set;
      if (wr_mask) begin
        irq_mask_q <= hwdata[i2c_tx_pkg::irq_w-1:0];
      end
      irq <= |(irq_stat_q & irq_mask_q);
    end
  end

  // Status bits
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      bf_q <= 1'b0;
      rw_q <= 1'b0;
      start_q <= 1'b0;
      stop_q <= 1'b0;
      ack_status_bit_q <= 1'b0;
    end else begin
      if (ev.start) begin
        start_q <= 1'b1;
        stop_q <= 1'b0;
      end else if (ev.stop) begin
        start_q <= 1'b0;
        stop_q <= 1'b1;
        rw_q <= 1'b0;
      end
      if (state_q == st_addr && ev.scl_fall && cnt_q == i2c_tx_pkg::bits_per_byte
          && addr_hit) begin
        rw_q <= 1'b1;
      end
      if (state_q == st_mack && ev.scl_rise) begin
        ack_status_bit_q <= ev.sda;
      end
      // Hardware setting the buffer wins over a read clearing it
      if (wr_data || (state_q == st_addr && ev.scl_fall
          && cnt_q == i2c_tx_pkg::bits_per_byte && addr_hit)) begin
        bf_q <= 1'b1;
      end else if (rd_data || (state_q == st_hold && ctrl_q[i2c_tx_pkg::ctrl_ckp_bit])) begin
        bf_q <= 1'b0;
      end
    end
  end

  // Protocol state, shifter and buffer
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      state_q <= st_idle;
      shift_q <= 8'h00;
      buf_q <= 8'h00;
      cnt_q <= 4'h0;
    end else begin
      if (wr_data) begin
        buf_q <= hwdata[7:0];
        shift_q <= hwdata[7:0];
      end
      if (!ctrl_q[i2c_tx_pkg::ctrl_en_bit]) begin
        state_q <= st_idle;
      end else if (ev.start) begin
        // Restart also drops any addressing in progress
        state_q <= st_addr;
        cnt_q <= 4'h0;
      end else if (ev.stop) begin
        state_q <= st_idle;
      end else begin
        case (state_q)
          st_idle: state_q <= st_idle;
          st_addr: begin
            if (ev.scl_rise) begin
              shift_q <= {shift_q[6:0], ev.sda};
              cnt_q <= cnt_q + 4'h1;
            end else if (ev.scl_fall && cnt_q == i2c_tx_pkg::bits_per_byte) begin
              // Write requests belong to the receive path; ignore here
              if (addr_hit) begin
                buf_q <= shift_q;
                state_q <= st_aack;
              end else begin
                state_q <= st_idle;
              end
            end
          end
          st_aack: begin
            if (ev.scl_fall) begin
              state_q <= st_hold;
            end
          end
          st_hold: begin
            if (ctrl_q[i2c_tx_pkg::ctrl_ckp_bit]) begin
              cnt_q <= 4'h0;
              state_q <= st_tx;
            end
          end
          st_tx: begin
            if (collide && ctrl_q[i2c_tx_pkg::ctrl_slave_collision_detect_en_bit]) begin
              state_q <= st_idle;
            end else if (ev.scl_fall) begin
              shift_q <= {shift_q[6:0], 1'b0};
              cnt_q <= cnt_q + 4'h1;
              if (cnt_q == i2c_tx_pkg::bits_per_byte - 4'h1) begin
                state_q <= st_mack;
              end
            end
          end
          st_mack: begin
            if (ev.scl_fall) begin
              state_q <= ack_status_bit_q ? st_idle : st_hold;
            end
          end
          default: state_q <= st_idle;
        endcase
      end
    end
  end

  // Pin drivers: only pull low; SDA leads the SCL release by one cycle
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      scl_o <= 1'b0;
      sda_o <= 1'b0;
      scl_oe <= 1'b0;
      sda_oe <= 1'b0;
    end else begin
      scl_o <= 1'b0;
      sda_o <= 1'b0;
      scl_oe <= (state_q == st_hold);
      case (state_q)
        st_aack: sda_oe <= 1'b1;
        st_hold: sda_oe <= ctrl_q[i2c_tx_pkg::ctrl_ckp_bit] & ~shift_q[7];
        st_tx: sda_oe <= ~shift_q[7];
        default: sda_oe <= 1'b0;
      endcase
    end
  end
endmodule : i2c_slave_transmit
`default_nettype wire

// file: tb/i2c_tx_props.sv
/*
  Concurrent checks on the slave transmit block's register bus and pads.
  Assumes it is bound to the top module and sees only its ports.
*/
`timescale 1ns/10ps
`default_nettype none
module i2c_tx_props (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  input wire logic [31:0] hrdata,
  input wire logic hreadyout,
  input wire logic hresp,
  input wire logic scl_i,
  input wire logic scl_o,
  input wire logic scl_oe,
  input wire logic sda_o,
  input wire logic sda_oe,
  input wire logic irq
);
  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);
  // Read address phase taken at one offset
  sequence rd_at(logic [7:0] a);
    hsel && hready && htrans[1] && !hwrite && haddr[7:0] == a;
  endsequence
  // Mask written with every event disabled
  sequence mask_off;
    hsel && hready && htrans[1] && hwrite && haddr[7:0] == i2c_tx_pkg::irq_mask_off
      ##1 hwdata[1:0] == 2'h0;
  endsequence
  bus_okay_a: assert property (hreadyout && !hresp)
    else $error("bus answer not ready or not okay");
  pads_low_a: assert property (!scl_o && !sda_o)
    else $error("pad drives a high level");
  sda_steady_a: assert property (scl_i && $past(scl_i) && $past(scl_i, 2) |-> $stable(sda_oe))
    else $error("data line moved while clock high");
  // Stretch may only start inside a low phase
  stretch_low_a: assert property ($rose(scl_oe) |-> !$past(scl_i))
    else $error("clock stretch began in a high phase");
  ack_free_a: assert property ($rose(scl_oe) |-> ##[0:2] !sda_oe)
    else $error("data line still held at stretch");
  ctrl_rsvd_a: assert property (rd_at(i2c_tx_pkg::ctrl_off) |=>
    hrdata[31:15] == 17'h0 && hrdata[7:4] == 4'h0)
    else $error("control unused bits not zero");
  status_rsvd_a: assert property (rd_at(i2c_tx_pkg::status_off) |=> hrdata[31:6] == 26'h0)
    else $error("status unused bits not zero");
  unmapped_zero_a: assert property (rd_at(8'h14) |=> hrdata == 32'h0)
    else $error("unmapped read not zero");
  irq_masked_a: assert property (mask_off |-> ##[1:2] !irq)
    else $error("interrupt stays high with all masked");
endmodule : i2c_tx_props
bind i2c_slave_transmit i2c_tx_props u_props (.hclk, .hresetn, .hsel, .haddr, .htrans,
  .hwrite, .hwdata, .hready, .hrdata, .hreadyout, .hresp, .scl_i, .scl_o, .scl_oe,
  .sda_o, .sda_oe, .irq);
`default_nettype wire

// file: tb/i2c_master_model.sv
/*
  Behavioural two-wire bus master facing the slave.
  Assumes the bench resolves both open-drain wires with pull-ups.
*/
`timescale 1ns/10ps
`default_nettype none
module i2c_master_model (
  input wire logic scl,
  input wire logic sda,
  output var logic scl_low,
  output var logic sda_low
);
  logic clash; // Pulls data bits low to provoke a collision
  initial begin
    scl_low = 1'h0;
    sda_low = 1'h0;
    clash = 1'h0;
  end
  // One bit; waits out any stretch before the high phase
  task automatic clk_bit(input logic b, output logic r);
    #12 sda_low = !b;
    #12 scl_low = 1'h0;
    wait (scl);
    #12 r = sda;
    #12 scl_low = 1'h1;
  endtask : clk_bit
  // Start or restart: data falls while clock high
  task automatic start_cond();
    #12 sda_low = 1'h0;
    #12 scl_low = 1'h0;
    wait (scl);
    #12 sda_low = 1'h1;
    #12 scl_low = 1'h1;
  endtask : start_cond
  // Stop: data rises while clock high
  task automatic stop_cond();
    #12 sda_low = 1'h1;
    #12 scl_low = 1'h0;
    wait (scl);
    #12 sda_low = 1'h0;
    #36;
  endtask : stop_cond
  // Address byte MSB first; extra low time lets a stretch land first
  task automatic send_byte(input logic [7:0] b, output logic ack);
    logic r;
    for (int i = 7; i >= 0; i--) clk_bit(b[i], r);
    clk_bit(1'h1, r);
    ack = !r;
    #24;
  endtask : send_byte
  // Data byte in, then our own answer
  task automatic recv_byte(input logic nack, output logic [7:0] b);
    logic r;
    for (int i = 7; i >= 0; i--) begin
      clk_bit(!clash, r);
      b[i] = r;
    end
    clk_bit(nack, r);
    #24;
  endtask : recv_byte
endmodule : i2c_master_model
`default_nettype wire

// file: tb/i2c_slave_transmit_bench.sv
/*
  Self-checking bench for the slave transmit block: AHB-Lite register
  master, bus master model and a queue model of the bytes sent.
  Assumes pull-ups on both wires and hready tied to hreadyout.
*/
`timescale 1ns/10ps
`default_nettype none
module i2c_slave_transmit_bench;
  logic hclk = 1'h0; // 200 MHz system clock
  logic hresetn = 1'h0;
  logic hsel = 1'h0;
  logic hwrite = 1'h0;
  logic [1:0] htrans = 2'h0;
  logic [2:0] hsize = 3'h2; // Word transfers only
  logic [31:0] haddr = 32'h0;
  logic [31:0] hwdata = 32'h0;
  logic [31:0] hrdata;
  logic hreadyout, hresp, scl_o, scl_oe, sda_o, sda_oe, irq;
  logic scl_low, sda_low;
  wire logic scl = !(scl_oe || scl_low); // Wired-AND with pull-up
  wire logic sda = !(sda_oe || sda_low);
  int num_errors = 0;
  int compares = 0;
  logic [7:0] txq[$]; // Bytes software loaded, in order
  logic [6:0] own; // Random own address
  always #2.5 hclk = !hclk;
  i2c_slave_transmit u_dut (.hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite, .hsize,
    .hwdata, .hready(hreadyout), .hrdata, .hreadyout, .hresp, .scl_i(scl), .scl_o,
    .scl_oe, .sda_i(sda), .sda_o, .sda_oe, .irq);
  i2c_master_model u_master (.scl, .sda, .scl_low, .sda_low);
  // Compare and count
  task automatic chk(input string n, input logic [31:0] seen, input logic [31:0] exp);
    compares++;
    if (seen !== exp) begin
      num_errors++;
      $display("ERROR %s expected %h seen %h", n, exp, seen);
    end
  endtask : chk
  // One single transfer; holds each phase until hready is seen high
  task automatic ahb(input logic w, input logic [7:0] a, input logic [31:0] wd,
    output logic [31:0] r);
    @(posedge hclk);
    hsel <= 1'h1;
    htrans <= 2'h2;
    hwrite <= w;
    haddr <= {24'h0, a};
    do @(posedge hclk); while (hreadyout !== 1'h1);
    hsel <= 1'h0;
    htrans <= 2'h0;
    hwdata <= wd;
    do @(posedge hclk); while (hreadyout !== 1'h1);
    r = hrdata;
  endtask : ahb
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] r;
    ahb(1'h1, a, d, r);
  endtask : wr
  // Read and compare the masked bits
  task automatic rdc(input string n, input logic [7:0] a, input logic [31:0] m,
    input logic [31:0] e);
    logic [31:0] r;
    ahb(1'h0, a, 32'h0, r);
    chk(n, r & m, e);
  endtask : rdc
  // Control word: enable, start interrupt and collision detect on
  function automatic logic [31:0] ctl(input logic clock_release_bit);
    return {17'h0, own, 4'h0, 2'h3, clock_release_bit, 1'h1};
  endfunction : ctl
  task automatic report_and_stop();
    $display("compares %0d errors %0d", compares, num_errors);
    if (num_errors == 0 && compares > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask : report_and_stop
  // Watchdog far beyond the few microseconds the tests take
  initial begin
    #100000;
    chk("watchdog", 32'h1, 32'h0);
    report_and_stop();
  end
  // Main sequence
  initial begin
    logic [7:0] b;
    logic ack;
    void'($urandom(91510));
    own = 7'h01 + 7'($urandom % 126);
    repeat (3) @(posedge hclk);
    hresetn <= 1'h1;
    rdc("ctrl rst", i2c_tx_pkg::ctrl_off, 32'hffffffff, 32'h0);
    rdc("status rst", i2c_tx_pkg::status_off, 32'hffffffff, 32'h0);
    rdc("flags rst", i2c_tx_pkg::irq_stat_off, 32'hffffffff, 32'h0);
    rdc("mask rst", i2c_tx_pkg::irq_mask_off, 32'hffffffff, 32'h0);
    rdc("unmapped", 8'h14, 32'hffffffff, 32'h0);
    $display("test reset done");
    wr(i2c_tx_pkg::irq_mask_off, 32'h0);
    wr(i2c_tx_pkg::ctrl_off, ctl(1'h0));
    u_master.start_cond();
    rdc("start seen", i2c_tx_pkg::status_off, 32'h4, 32'h4);
    rdc("start flag", i2c_tx_pkg::irq_stat_off, 32'h1, 32'h1);
    chk("irq masked", irq, 32'h0);
    wr(i2c_tx_pkg::irq_mask_off, 32'h3);
    repeat (2) @(posedge hclk);
    chk("irq unmasked", irq, 32'h1);
    wr(i2c_tx_pkg::irq_stat_off, 32'h1);
    repeat (2) @(posedge hclk);
    chk("irq cleared", irq, 32'h0);
    // Read address, then three bytes, the last one refused
    u_master.send_byte({own, 1'h1}, ack);
    chk("addr ack", ack, 32'h1);
    repeat (4) @(posedge hclk);
    chk("addr stretch", scl_oe, 32'h1);
    rdc("rw bf", i2c_tx_pkg::status_off, 32'h23, 32'h23);
    rdc("addr buffer", i2c_tx_pkg::data_off, 32'hff, {24'h0, own, 1'h1});
    rdc("bf clear", i2c_tx_pkg::status_off, 32'h1, 32'h0);
    rdc("addr flag", i2c_tx_pkg::irq_stat_off, 32'h1, 32'h1);
    wr(i2c_tx_pkg::irq_stat_off, 32'h1);
    for (int k = 0; k < 3; k++) begin
      txq.push_back(8'($urandom));
      wr(i2c_tx_pkg::data_off, {24'h0, txq[$]});
      wr(i2c_tx_pkg::ctrl_off, ctl(1'h1));
      u_master.recv_byte(k == 2, b);
      chk("byte out", b, txq.pop_front());
      repeat (4) @(posedge hclk);
      chk("byte stretch", scl_oe, k != 2);
      rdc("ack_status_bit", i2c_tx_pkg::status_off, 32'h10, (k == 2) << 4);
      rdc("byte flag", i2c_tx_pkg::irq_stat_off, 32'h1, 32'h1);
      wr(i2c_tx_pkg::irq_stat_off, 32'h1);
    end
    u_master.stop_cond();
    rdc("unaddressed", i2c_tx_pkg::status_off, 32'h20, 32'h0);
    $display("test transfer done");
    // Foreign address and a write request are both refused
    u_master.start_cond();
    u_master.send_byte({own ^ 7'h01, 1'h1}, ack);
    chk("foreign ack", ack, 32'h0);
    u_master.start_cond();
    u_master.send_byte({own, 1'h0}, ack);
    chk("write ack", ack, 32'h0);
    u_master.stop_cond();
    $display("test refusal done");
    // Collision on a released one bit
    u_master.start_cond();
    u_master.send_byte({own, 1'h1}, ack);
    rdc("addr again", i2c_tx_pkg::data_off, 32'hff, {24'h0, own, 1'h1});
    wr(i2c_tx_pkg::data_off, 32'hff);
    wr(i2c_tx_pkg::ctrl_off, ctl(1'h1));
    u_master.clash = 1'h1;
    u_master.recv_byte(1'h1, b);
    u_master.clash = 1'h0;
    rdc("collision", i2c_tx_pkg::irq_stat_off, 32'h2, 32'h2);
    rdc("coll idle", i2c_tx_pkg::status_off, 32'h20, 32'h0);
    chk("coll irq", irq, 32'h1);
    // Masking everything must drop the line while flags stay set
    wr(i2c_tx_pkg::irq_mask_off, 32'h0);
    repeat (2) @(posedge hclk);
    chk("irq remasked", irq, 32'h0);
    wr(i2c_tx_pkg::irq_mask_off, 32'h3);
    u_master.stop_cond();
    $display("test collision done");
    report_and_stop();
  end
endmodule : i2c_slave_transmit_bench
`default_nettype wire
